// ==== logic/osd_font_defines.vh ====
// Purpose: constants for the on-screen-display glyph source and font memory
// Assumes: 4-bit register subaddress, 9-bit glyph index
// Notes:   definitions only
`ifndef OSD_FONT_DEFINES_VH
`define OSD_FONT_DEFINES_VH
// register subaddresses
`define ADR_GLYPH_W      4'h0
`define ADR_GLYPH_H      4'h1
`define ADR_SL_GEOM      4'h2
`define ADR_SL_STYLE     4'h3
`define ADR_MONO_LO      4'h4
`define ADR_MONO_HI      4'h5
`define ADR_LOAD_HI      4'h6
`define ADR_LOAD_LO      4'h7
`define ADR_LOAD_MASK    4'h8
`define ADR_LOAD_DATA    4'h9
`define ADR_PTR_LO       4'hA
`define ADR_PTR_HI       4'hB
// field positions
`define BIT_SINGLE_GLYPH 7
`define BIT_SL_STYLE     4
// reset values
`define RST_GLYPH_W      6'h0C
`define RST_GLYPH_H      6'h12
`define RST_BYTE         8'h00
`define RST_MASK         8'hFF
// glyph size limits and native rom size
`define SIZE_MIN         6'h08
`define SIZE_MAX         6'h20
`define ROM_W            6'h0C
`define ROM_H            6'h12
// glyph index map
`define ROM_LAST         9'h15F
`define GEN_FIRST        9'h160
`define BORDER_LAST      9'h1D1
`define SL_H_START       9'h1D2
`define SL_H_FILL0       9'h1D3
`define SL_H_END         9'h1E3
`define SL_V_END         9'h1E4
`define SL_V_FILL0       9'h1E5
`define SL_V_START       9'h1F6
// rom subrange bounds
`define ROM_MC_SINGLE    9'h020
`define ROM_SC_DUAL      9'h030
`define ROM_SC_SINGLE    9'h050
`define ROM_TEXT         9'h060
`define ROM_KANA         9'h113
// slider native pixels per middle glyph
`define SL_NATIVE_PX     11'h010
`endif

// ==== logic/font_ram.v ====
// Purpose: 4 kbyte font memory, bit-exact masked byte write, pixel read
// Assumes: write pointer and read address are bit addresses, msb first
// Notes:   storage is flip-flops with no reset; contents undefined at power up
module font_ram (
	// clock
	input  wire        core_clk,
	// masked write
	input  wire        wr_en,
	input  wire [14:0] wr_ptr,
	input  wire [7:0]  wr_data,
	input  wire [7:0]  wr_mask,
	// pixel read
	input  wire [14:0] rd_addr,
	output wire [1:0]  rd_bits
);
	reg  [7:0]  mem [0:4095];
	wire [11:0] ba  = wr_ptr[14:3];
	wire [11:0] ba1 = ba + 12'h001;
	// RQ18: msb first placement
	wire [15:0] d16 = {wr_data, 8'h00} >> wr_ptr[2:0];
	wire [15:0] m16 = {wr_mask, 8'h00} >> wr_ptr[2:0];
	wire [7:0]  rb  = mem[rd_addr[14:3]];
	wire [2:0]  rs  = rd_addr[2:0];

	////////////////////////////////////////////////////////////////////
	// write spans up to two bytes; unmasked bits keep old contents
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[ba]  <= (mem[ba] & ~m16[15:8]) | (d16[15:8] & m16[15:8]);
			mem[ba1] <= (mem[ba1] & ~m16[7:0]) | (d16[7:0] & m16[7:0]);
		end
	end

	////////////////////////////////////////////////////////////////////
	// first bit at address, second the next lower bit of the byte
	assign rd_bits[1] = rb[3'd7 - rs];
	assign rd_bits[0] = (rs == 3'd7) ? 1'b0 : rb[3'd6 - rs];
endmodule

// ==== logic/osd_font_source.v ====
// Purpose: glyph source select, rom placement, border and slider generators,
//          user font memory with masked glyph loading
// Assumes: register writes arrive decoded, one cycle each; pixel inputs sync
// Notes:   pixel result two clocks after the request, rom answers in between
`include "osd_font_defines.vh"
// Behaviour
// RQ1: indices 000H..15FH come from the glyph ROM, native 12 by 18.
// RQ2: ROM glyphs centred in larger cells, cropped in smaller cells.
// RQ3: indices 160H..1F6H come from generators at programmed cell size.
// RQ4: border glyphs fixed shape scaled; sliders drawn from slider registers.
// RQ5: ROM subranges ordered multicolour, single colour, text, Japanese set.
// RQ6: slider fields: border, inset, gap, each 4 bits in pixels.
// RQ7: style 0 solid fill, style 1 single marker at position.
// RQ8: slider start 1D2H or 1F6H, end 1E3H or 1E4H, grades between.
// RQ9: 16 pixels per middle glyph, grades skipped or doubled by size.
// RQ10: one font size for memory, 8 to 32 pixels each way.
// RQ11: single colour pixel one bit, multicolour pixel two bits.
// RQ12: single colour bit 0 background, 1 foreground colour.
// RQ13: multicolour pixel indexes one of four palette entries.
// RQ14: memory holds up to 512 single colour 8 by 8 glyphs.
// RQ15: multicolour from address 0, below start code multicolour.
// RQ16: controller writes 000H for mono only, bit 8 for multicolour only.
// RQ17: load index first, then data bytes with an 8-bit mask.
// RQ18: data bytes msb first in pixel scan order, several per glyph.
// RQ19: pointer recomputed on index write, plus 8 per data write.
// RQ20: only mask-enabled bits change in font memory.
// RQ21: single-glyph flag masks writes past the glyph end.
// RQ22: register address stays on the data register after its writes.
// RQ23: per-element select chooses ROM/generator space or font memory.
// RQ24: 1D1H is last border glyph; sliders begin at 1D2H.
module osd_font_source (
	// clock and reset
	input  wire       core_clk,
	input  wire       nrst,
	// register access
	input  wire       reg_wr_en,
	input  wire [3:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rd_data,
	output wire [3:0] reg_next_addr,
	// pixel request
	input  wire [8:0] pix_glyph_index,
	input  wire       pix_use_ram,
	input  wire [4:0] pix_col,
	input  wire [4:0] pix_row,
	input  wire [3:0] pix_fg_colour,
	input  wire [3:0] pix_bg_colour,
	input  wire [1:0] pix_palette_sel,
	// glyph rom
	output reg  [8:0] rom_glyph,
	output reg  [3:0] rom_col,
	output reg  [4:0] rom_row,
	output reg  [2:0] rom_region,
	input  wire [1:0] rom_bits,
	// pixel result
	output reg  [3:0] out_colour,
	output reg        out_palette
);
	reg  [5:0]  glyph_width_px;
	reg  [5:0]  glyph_height_px;
	reg  [7:0]  slider_geometry;
	reg  [7:0]  slider_style_and_spacing;
	reg  [8:0]  mono_glyph_first_index;
	reg         single_glyph;
	reg  [8:0]  glyph_load_index;
	reg  [7:0]  glyph_load_mask;
	reg  [15:0] wptr;
	reg  [20:0] wend;
	reg  [8:0]  s1_idx;
	reg         s1_ram;
	reg  [4:0]  s1_col;
	reg  [4:0]  s1_row;
	reg  [3:0]  s1_fg;
	reg  [3:0]  s1_bg;
	reg  [1:0]  s1_pal;
	reg         rom_hit;

	////////////////////////////////////////////////////////////////////
	// bit address of a glyph's first pixel in font memory
	// sizes come in as arguments so continuous callers follow register changes
	// RQ15: multicolour glyphs first
	function [20:0] glyph_base;
		input [8:0]  idx;
		input [8:0]  mono;
		input [10:0] bits;
		begin
			if (idx < mono)
				glyph_base = {idx, 1'b0} * bits;
			else
				glyph_base = {mono, 1'b0} * bits + (idx - mono) * bits;
		end
	endfunction

	function [20:0] glyph_bits;
		input [8:0]  idx;
		input [8:0]  mono;
		input [10:0] bits;
		begin
			if (idx < mono)
				glyph_bits = {9'h000, bits, 1'b0};
			else
				glyph_bits = {10'h000, bits};
		end
	endfunction

	function [5:0] clamp_size;
		input [7:0] v;
		begin
			if (v < {2'b00, `SIZE_MIN})
				clamp_size = `SIZE_MIN;
			else if (v > {2'b00, `SIZE_MAX})
				clamp_size = `SIZE_MAX;
			else
				clamp_size = v[5:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// register writes and load pointer
	wire        wr_data = reg_wr_en && (reg_addr == `ADR_LOAD_DATA);
	wire [8:0]  idx_hi  = {reg_wdata[0], glyph_load_index[7:0]};
	wire [8:0]  idx_lo  = {glyph_load_index[8], reg_wdata};
	wire [10:0] cell_bits = glyph_width_px * glyph_height_px;
	wire [20:0] base_hi = glyph_base(idx_hi, mono_glyph_first_index, cell_bits);
	wire [20:0] base_lo = glyph_base(idx_lo, mono_glyph_first_index, cell_bits);
	wire [20:0] end_hi  = base_hi + glyph_bits(idx_hi, mono_glyph_first_index, cell_bits);
	wire [20:0] end_lo  = base_lo + glyph_bits(idx_lo, mono_glyph_first_index, cell_bits);
	wire [20:0] remain  = wend - {5'h00, wptr};
	reg  [7:0]  load_mask;

	// RQ21: end-of-glyph masking
	always @* begin
		load_mask = glyph_load_mask;
		if (single_glyph) begin
			if (remain[20] || remain == 21'h0)
				load_mask = 8'h00;
			else if (remain < 21'h8)
				load_mask = glyph_load_mask & ~(8'hFF >> remain[2:0]);
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			glyph_width_px           <= `RST_GLYPH_W;
			glyph_height_px          <= `RST_GLYPH_H;
			slider_geometry          <= `RST_BYTE;
			slider_style_and_spacing <= `RST_BYTE;
			mono_glyph_first_index   <= 9'h000;
			single_glyph             <= 1'b0;
			glyph_load_index         <= 9'h000;
			glyph_load_mask          <= `RST_MASK;
			wptr                     <= 16'h0000;
			wend                     <= 21'h000000;
		end else if (reg_wr_en) begin
			case (reg_addr)
				// RQ10: size held in range
				`ADR_GLYPH_W:   glyph_width_px  <= clamp_size(reg_wdata);
				`ADR_GLYPH_H:   glyph_height_px <= clamp_size(reg_wdata);
				`ADR_SL_GEOM:   slider_geometry <= reg_wdata;
				`ADR_SL_STYLE:  slider_style_and_spacing <= reg_wdata;
				`ADR_MONO_LO:   mono_glyph_first_index[7:0] <= reg_wdata;
				`ADR_MONO_HI:   mono_glyph_first_index[8] <= reg_wdata[0];
				`ADR_LOAD_HI: begin
					single_glyph     <= reg_wdata[`BIT_SINGLE_GLYPH];
					glyph_load_index <= idx_hi;
					// RQ19: pointer from index
					wptr <= base_hi[15:0];
					wend <= end_hi;
				end
				`ADR_LOAD_LO: begin
					glyph_load_index <= idx_lo;
					// RQ19: pointer from index
					wptr <= base_lo[15:0];
					wend <= end_lo;
				end
				// RQ17: mask for data bytes
				`ADR_LOAD_MASK: glyph_load_mask <= reg_wdata;
				// RQ19: advance by one byte
				`ADR_LOAD_DATA: wptr <= wptr + 16'h0008;
				default:        wptr <= wptr;
			endcase
		end
	end

	// RQ22: address holds on the data register
	assign reg_next_addr = (reg_addr == `ADR_LOAD_DATA) ? reg_addr : reg_addr + 4'h1;

	// readback, one clock late
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rd_data <= 8'h00;
		end else begin
			case (reg_addr)
				`ADR_GLYPH_W:   reg_rd_data <= {2'b00, glyph_width_px};
				`ADR_GLYPH_H:   reg_rd_data <= {2'b00, glyph_height_px};
				`ADR_SL_GEOM:   reg_rd_data <= slider_geometry;
				`ADR_SL_STYLE:  reg_rd_data <= slider_style_and_spacing;
				`ADR_MONO_LO:   reg_rd_data <= mono_glyph_first_index[7:0];
				`ADR_MONO_HI:   reg_rd_data <= {7'h00, mono_glyph_first_index[8]};
				`ADR_LOAD_HI:   reg_rd_data <= {single_glyph, 6'h00, glyph_load_index[8]};
				`ADR_LOAD_LO:   reg_rd_data <= glyph_load_index[7:0];
				`ADR_LOAD_MASK: reg_rd_data <= glyph_load_mask;
				`ADR_PTR_LO:    reg_rd_data <= wptr[7:0];
				`ADR_PTR_HI:    reg_rd_data <= wptr[15:8];
				default:        reg_rd_data <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// stage 1: capture request and place rom glyph in the cell
	wire [5:0] dx = (glyph_width_px > `ROM_W) ? ((glyph_width_px - `ROM_W) >> 1) : 6'h00;
	wire [5:0] dy = (glyph_height_px > `ROM_H) ? ((glyph_height_px - `ROM_H) >> 1) : 6'h00;
	wire [6:0] cx = {2'b00, pix_col} - {1'b0, dx};
	wire [6:0] cy = {2'b00, pix_row} - {1'b0, dy};
	wire [8:0] gi = pix_glyph_index;
	reg  [2:0] next_region;

	// RQ5: rom subrange class
	always @* begin
		if (gi < `ROM_MC_SINGLE)
			next_region = 3'h0;
		else if (gi < `ROM_SC_DUAL)
			next_region = 3'h1;
		else if (gi < `ROM_SC_SINGLE)
			next_region = 3'h2;
		else if (gi < `ROM_TEXT)
			next_region = 3'h3;
		else if (gi < `ROM_KANA)
			next_region = 3'h4;
		else
			next_region = 3'h5;
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_idx     <= 9'h000;
			s1_ram     <= 1'b0;
			s1_col     <= 5'h00;
			s1_row     <= 5'h00;
			s1_fg      <= 4'h0;
			s1_bg      <= 4'h0;
			s1_pal     <= 2'h0;
			rom_glyph  <= 9'h000;
			rom_col    <= 4'h0;
			rom_row    <= 5'h00;
			rom_region <= 3'h0;
			rom_hit    <= 1'b0;
		end else begin
			s1_idx     <= gi;
			s1_ram     <= pix_use_ram;
			s1_col     <= pix_col;
			s1_row     <= pix_row;
			s1_fg      <= pix_fg_colour;
			s1_bg      <= pix_bg_colour;
			s1_pal     <= pix_palette_sel;
			rom_glyph  <= gi;
			// RQ2: centre or crop
			rom_col    <= cx[3:0];
			rom_row    <= cy[4:0];
			rom_hit    <= !cx[6] && !cy[6] && (cx[5:0] < `ROM_W) && (cy[5:0] < `ROM_H);
			rom_region <= next_region;
		end
	end

	////////////////////////////////////////////////////////////////////
	// font memory read of the captured pixel
	wire        s1_multi = s1_idx < mono_glyph_first_index;
	wire [10:0] scan     = s1_row * glyph_width_px + {6'h00, s1_col};
	wire [20:0] rd_base  = glyph_base(s1_idx, mono_glyph_first_index, cell_bits);
	// RQ11: one or two bits per pixel
	wire [20:0] rd_full  = rd_base + (s1_multi ? {scan, 1'b0} : {1'b0, scan});
	wire [1:0]  ram_bits;

	// RQ14: 4 kbyte glyph store
	font_ram u_font_ram (
		.core_clk (core_clk),
		// RQ20: masked write
		.wr_en    (wr_data),
		.wr_ptr   (wptr[14:0]),
		.wr_data  (reg_wdata),
		.wr_mask  (load_mask),
		.rd_addr  (rd_full[14:0]),
		.rd_bits  (ram_bits)
	);

	////////////////////////////////////////////////////////////////////
	// generators: border glyphs and slider parts
	wire [8:0]  bsub = s1_idx - `GEN_FIRST;
	wire [5:0]  th_x = {3'b000, glyph_width_px[5:3]};
	wire [5:0]  th_y = {3'b000, glyph_height_px[5:3]};
	wire [5:0]  mcol = glyph_width_px - 6'h01 - {1'b0, s1_col};
	wire [5:0]  mrow = glyph_height_px - 6'h01 - {1'b0, s1_row};
	wire        vert = s1_idx >= `SL_V_END;
	wire [5:0]  ln_p = vert ? glyph_height_px : glyph_width_px;
	wire [5:0]  p    = vert ? mrow : {1'b0, s1_col};
	wire [5:0]  q    = vert ? {1'b0, s1_col} : {1'b0, s1_row};
	wire [5:0]  qm   = vert ? mcol : mrow;
	wire [5:0]  pm   = vert ? {1'b0, s1_row} : mcol;
	// RQ6: slider fields in pixels
	wire [5:0]  off  = {2'b00, slider_geometry[3:0]};
	wire [5:0]  brd  = {2'b00, slider_geometry[7:4]};
	wire [5:0]  c0   = off + brd + {2'b00, slider_style_and_spacing[3:0]};
	wire        peak = slider_style_and_spacing[`BIT_SL_STYLE];
	wire [8:0]  gsub = s1_idx - (vert ? `SL_V_FILL0 : `SL_H_FILL0);
	wire [10:0] fpos = {5'h00, p} * `SL_NATIVE_PX;
	wire [10:0] fend = fpos + `SL_NATIVE_PX;
	wire [10:0] glev = gsub[4:0] * ln_p;
	wire        bq   = (q >= off && q < off + brd) || (qm >= off && qm < off + brd);
	wire        cq   = (q >= c0) && (qm >= c0);
	wire        inq  = (q >= off) && (qm >= off);
	wire        is_start = (s1_idx == `SL_H_START) || (s1_idx == `SL_V_START);
	wire        is_end   = (s1_idx == `SL_H_END) || (s1_idx == `SL_V_END);
	reg  [1:0]  gen_pix;
	reg         gen_multi;

	always @* begin
		gen_pix   = 2'h0;
		gen_multi = 1'b0;
		// RQ24: 1D1H closes the border range
		if (s1_idx <= `BORDER_LAST) begin
			// RQ4: fixed edges scaled to cell
			gen_pix[0] = (bsub[0] && s1_row <= th_y[4:0]) || (bsub[1] && mrow <= th_y)
				|| (bsub[2] && s1_col <= th_x[4:0]) || (bsub[3] && mcol <= th_x)
				|| (bsub[4] && s1_row == glyph_height_px[5:1])
				|| (bsub[5] && s1_col == glyph_width_px[5:1]);
		end else begin
			gen_multi = 1'b1;
			// RQ8: start and end caps
			if (is_start) begin
				if ((bq && p >= off) || (inq && p >= off && p < off + brd))
					gen_pix = 2'h1;
			end else if (is_end) begin
				if ((bq && pm >= off) || (inq && pm >= off && pm < off + brd))
					gen_pix = 2'h1;
			end else if (bq) begin
				gen_pix = 2'h1;
			// RQ9: grades scaled by cell length
			end else if (cq && fpos < glev) begin
				// RQ7: fill or marker
				if (!peak || fend >= glev)
					gen_pix = 2'h2;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// stage 2: pick the source and resolve colour
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			out_colour  <= 4'h0;
			out_palette <= 1'b0;
		// RQ23: per-element source select
		end else if (s1_ram) begin
			out_palette <= s1_multi;
			// RQ13: palette entry
			if (s1_multi)
				out_colour <= {s1_pal, ram_bits};
			// RQ12: background or foreground
			else
				out_colour <= ram_bits[1] ? s1_fg : s1_bg;
		// RQ1: rom space
		end else if (s1_idx <= `ROM_LAST) begin
			out_palette <= rom_hit && (rom_region < 3'h2);
			if (!rom_hit)
				out_colour <= s1_bg;
			else if (rom_region < 3'h2)
				out_colour <= {s1_pal, rom_bits};
			else
				out_colour <= rom_bits[0] ? s1_fg : s1_bg;
		// RQ3: generated at cell size
		end else begin
			out_palette <= gen_multi;
			if (gen_multi)
				out_colour <= {s1_pal, gen_pix};
			else
				out_colour <= gen_pix[0] ? s1_fg : s1_bg;
		end
	end
endmodule

// ==== verification/glyph_rom_model.sv ====
// Purpose: glyph rom seen from the font source, answers in the same cycle
// Assumes: native glyph cell of 12 by 18 pixels
// Notes:   pattern is arbitrary but predictable from the request
module glyph_rom_model (
	// rom request
	input  wire logic [8:0] rom_glyph,
	input  wire logic [3:0] rom_col,
	input  wire logic [4:0] rom_row,
	// rom answer
	output logic      [1:0] rom_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	assign rom_bits = (rom_col < 4'hC && rom_row < 5'h12) ?
		{rom_row[0] ^ rom_glyph[0], rom_col[0]} : 2'h0;
endmodule

// ==== verification/osd_font_source_checker.sv ====
// Purpose: port-level checks of the glyph source
// Assumes: one clock, asynchronous active-low reset
// Notes:   attached to the font source by bind
`include "osd_font_defines.vh"
module osd_font_source_checker (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       nrst,
	// register access
	input wire logic       reg_wr_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rd_data,
	input wire logic [3:0] reg_next_addr,
	// pixel request and results
	input wire logic [8:0] pix_glyph_index,
	input wire logic       pix_use_ram,
	input wire logic [3:0] pix_fg_colour,
	input wire logic [3:0] pix_bg_colour,
	input wire logic [8:0] rom_glyph,
	input wire logic [2:0] rom_region,
	input wire logic [3:0] out_colour,
	input wire logic       out_palette
);
	timeunit 1ns;
	timeprecision 1ps;
	wire rom_req;
	wire is_w;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	// request for the fixed rom
	assign rom_req = !pix_use_ram && pix_glyph_index <= `ROM_LAST;
	assign is_w = reg_addr == `ADR_GLYPH_W;
	////////////////////////////////////////////////////////////////////////////
	a_next_addr_hold: assert property (reg_addr == `ADR_LOAD_DATA |->
		reg_next_addr == `ADR_LOAD_DATA) else $error("next address left the data register");
	a_next_addr_step: assert property (reg_addr != `ADR_LOAD_DATA |->
		reg_next_addr == reg_addr + 4'h1) else $error("next address not one up");
	a_rom_glyph_pass: assert property (rom_req |=>
		rom_glyph == $past(pix_glyph_index)) else $error("rom glyph not passed on");
	a_region_text_set: assert property (rom_req && pix_glyph_index >= `ROM_TEXT &&
		pix_glyph_index < `ROM_KANA |=> rom_region == 3'h4) else $error("text region");
	a_region_kana_set: assert property (rom_req && pix_glyph_index >= `ROM_KANA
		|=> rom_region == 3'h5) else $error("japanese region");
	a_region_multi_set: assert property (rom_req && pix_glyph_index < `ROM_MC_SINGLE
		|=> rom_region == 3'h0) else $error("multicolour region");
	a_width_floor_clamp: assert property (reg_wr_en && is_w && reg_wdata < 8'h08
		##1 is_w && !reg_wr_en |=> reg_rd_data == 8'h08) else $error("width floor");
	a_width_ceil_clamp: assert property (reg_wr_en && is_w && reg_wdata > 8'h20
		##1 is_w && !reg_wr_en |=> reg_rd_data == 8'h20) else $error("width ceiling");
	a_rom_mono_colour: assert property (rom_req && pix_glyph_index >= `ROM_SC_DUAL
		|-> ##2 !out_palette && (out_colour == $past(pix_fg_colour, 2) ||
		out_colour == $past(pix_bg_colour, 2))) else $error("mono rom colour");
	////////////////////////////////////////////////////////////////////////////
	// main scenarios reached
	c_data_burst: cover property (reg_wr_en && reg_addr == `ADR_LOAD_DATA ##2 reg_wr_en);
	c_ram_pixel: cover property (pix_use_ram ##2 !out_palette);
	c_palette_out: cover property (pix_use_ram ##2 out_palette);
	c_slider_pixel: cover property (!pix_use_ram && pix_glyph_index > `BORDER_LAST ##2 out_palette);
endmodule
bind osd_font_source osd_font_source_checker u_checker (
	.core_clk(core_clk), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .reg_next_addr(reg_next_addr),
	.pix_glyph_index(pix_glyph_index), .pix_use_ram(pix_use_ram),
	.pix_fg_colour(pix_fg_colour), .pix_bg_colour(pix_bg_colour),
	.rom_glyph(rom_glyph), .rom_region(rom_region), .out_colour(out_colour),
	.out_palette(out_palette)
);

// ==== verification/osd_font_source_bench.sv ====
// Purpose: register and pixel sequences against the glyph source
// Assumes: fixed colours and palette select on the pixel request
// Notes:   font memory is loaded before it is displayed
`include "osd_font_defines.vh"
module osd_font_source_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] FG = 4'h5;
	localparam logic [3:0] BG = 4'hA;
	logic       core_clk, nrst, reg_wr_en, pix_use_ram;
	logic [3:0] reg_addr, g_col;
	logic [7:0] reg_wdata, b;
	logic [8:0] pix_glyph_index, g_glyph;
	logic [4:0] pix_col, pix_row, g_row;
	logic [2:0] g_region;
	wire  [7:0] reg_rd_data;
	wire  [3:0] reg_next_addr, rom_col, out_colour;
	wire  [8:0] rom_glyph;
	wire  [4:0] rom_row;
	wire  [2:0] rom_region;
	wire  [1:0] rom_bits;
	wire        out_palette;
	int         bad_count, checked, i, c;
	logic [8:0] ridx [0:5] = '{9'h000, 9'h020, 9'h030, 9'h050, 9'h060, 9'h113};
	////////////////////////////////////////////////////////////////////////////
	osd_font_source DUT (.core_clk(core_clk), .nrst(nrst), .reg_wr_en(reg_wr_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data),
		.reg_next_addr(reg_next_addr), .pix_glyph_index(pix_glyph_index),
		.pix_use_ram(pix_use_ram), .pix_col(pix_col), .pix_row(pix_row),
		.pix_fg_colour(FG), .pix_bg_colour(BG), .pix_palette_sel(2'h2),
		.rom_glyph(rom_glyph), .rom_col(rom_col), .rom_row(rom_row),
		.rom_region(rom_region), .rom_bits(rom_bits), .out_colour(out_colour),
		.out_palette(out_palette));
	glyph_rom_model ROM (.rom_glyph(rom_glyph), .rom_col(rom_col), .rom_row(rom_row),
		.rom_bits(rom_bits));
	// clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] pat(input int r);
		pat = 8'h3C ^ r[7:0];
	endfunction
	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		@(posedge core_clk);
		#1;
		chk("reg_rd_data", 16'(reg_rd_data), 16'(e));
	endtask
	task px(input logic [8:0] idx, input logic u, input logic [4:0] cc, rr,
		input logic [3:0] ec, input logic ep);
		@(posedge core_clk);
		pix_glyph_index <= idx;
		pix_use_ram <= u;
		pix_col <= cc;
		pix_row <= rr;
		@(posedge core_clk);
		#1;
		{g_glyph, g_col, g_row, g_region} = {rom_glyph, rom_col, rom_row, rom_region};
		@(posedge core_clk);
		#1;
		chk("out_colour", 16'(out_colour), 16'(ec));
		chk("out_palette", 16'(out_palette), 16'(ep));
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		conclude;
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, reg_wr_en, reg_addr, reg_wdata, pix_glyph_index} = '0;
		{pix_use_ram, pix_col, pix_row, bad_count, checked} = '0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		// reset values and slider fields
		rd(`ADR_GLYPH_W, 8'h0C);
		rd(`ADR_GLYPH_H, 8'h12);
		rd(`ADR_SL_GEOM, 8'h00);
		rd(4'hC, 8'h00);
		rd(`ADR_LOAD_MASK, 8'hFF);
		chk("reg_next_addr", 16'(reg_next_addr), 16'h9);
		wr(`ADR_SL_GEOM, 8'hA5);
		rd(`ADR_SL_GEOM, 8'hA5);
		wr(`ADR_SL_STYLE, 8'h1F);
		rd(`ADR_SL_STYLE, 8'h1F);
		wr(`ADR_GLYPH_W, 8'h04);
		rd(`ADR_GLYPH_W, 8'h08);
		wr(`ADR_GLYPH_W, 8'h3F);
		rd(`ADR_GLYPH_W, 8'h20);
		wr(`ADR_PTR_LO, 8'h55);
		rd(`ADR_PTR_LO, 8'h00);
		// rom centred in 16 by 22
		wr(`ADR_GLYPH_W, 8'h10);
		wr(`ADR_GLYPH_H, 8'h16);
		for (i = 0; i < 6; i++) begin
			px(ridx[i], 0, 5, 6, (i < 2) ? 4'h9 : FG, i < 2);
			chk("rom_region", 16'(g_region), 16'(i));
			chk("rom_glyph", 16'(g_glyph), 16'(ridx[i]));
			chk("rom_pos", {g_col, 3'h0, g_row}, {4'h3, 3'h0, 5'h4});
		end
		px(9'h060, 0, 0, 6, BG, 0);
		wr(`ADR_GLYPH_W, 8'h08);
		wr(`ADR_GLYPH_H, 8'h08);
		wr(`ADR_MONO_LO, 8'h00);
		wr(`ADR_MONO_HI, 8'h00);
		wr(`ADR_LOAD_HI, 8'h00);
		wr(`ADR_LOAD_LO, 8'h00);
		wr(`ADR_LOAD_MASK, 8'hFF);
		for (i = 0; i < 8; i++)
			wr(`ADR_LOAD_DATA, pat(i));
		chk("reg_next_addr", 16'(reg_next_addr), 16'h9);
		rd(`ADR_PTR_LO, 8'h40);
		b = pat(2);
		for (c = 0; c < 8; c++)
			px(0, 1, c[4:0], 2, b[7 - c] ? FG : BG, 0);
		wr(`ADR_LOAD_LO, 8'h03);
		rd(`ADR_PTR_LO, 8'hC0);
		wr(`ADR_LOAD_LO, 8'h00);
		wr(`ADR_LOAD_MASK, 8'hF0);
		wr(`ADR_LOAD_DATA, 8'h00);
		wr(`ADR_LOAD_MASK, 8'hFF);
		b = 8'h0C;
		for (c = 0; c < 8; c++)
			px(0, 1, c[4:0], 0, b[7 - c] ? FG : BG, 0);
		// single glyph stops at its end
		wr(`ADR_LOAD_LO, 8'h02);
		wr(`ADR_LOAD_DATA, 8'h00);
		wr(`ADR_LOAD_HI, 8'h80);
		wr(`ADR_LOAD_LO, 8'h01);
		for (i = 0; i < 9; i++)
			wr(`ADR_LOAD_DATA, 8'hFF);
		px(1, 1, 0, 7, FG, 0);
		px(2, 1, 0, 0, BG, 0);
		wr(`ADR_MONO_HI, 8'h01);
		px(0, 1, 0, 0, 4'h8, 1);
		px(0, 1, 2, 0, 4'hB, 1);
		// generated glyphs in a 16 by 16 cell
		wr(`ADR_GLYPH_W, 8'h10);
		wr(`ADR_GLYPH_H, 8'h10);
		wr(`ADR_SL_GEOM, 8'h21);
		wr(`ADR_SL_STYLE, 8'h01);
		px(9'h161, 0, 3, 0, FG, 0);
		px(9'h161, 0, 3, 8, BG, 0);
		px(9'h1D1, 0, 3, 0, FG, 0);
		px(9'h1D2, 0, 1, 8, 4'h9, 1);
		px(9'h1DB, 0, 3, 8, 4'hA, 1);
		px(9'h1DB, 0, 12, 8, 4'h8, 1);
		px(9'h1DB, 0, 12, 1, 4'h9, 1);
		px(9'h1ED, 0, 8, 12, 4'hA, 1);
		wr(`ADR_SL_STYLE, 8'h11);
		px(9'h1DB, 0, 7, 8, 4'hA, 1);
		px(9'h1DB, 0, 3, 8, 4'h8, 1);
		conclude;
	end
endmodule
